// ==== include/pdm_map.vh ====
// Constants for the peripheral data mover: channel map, register offsets and reset values.
`ifndef PDM_MAP_VH
`define PDM_MAP_VH
`define PDM_NUM_CH        8
`define PDM_NUM_PERIPH    4
`define PDM_OFS_PTR       8'h30
`define PDM_OFS_CNT       8'h34
`define PDM_OFS_TPTR      8'h38
`define PDM_OFS_TCNT      8'h3c
`define PDM_PTR_RESET     32'h00000000
`define PDM_CNT_RESET     16'h0000
`define PDM_SPI_PERIPH    2'h3
`endif

// ==== hdl/pdm_channels.v ====
// Eight-channel peripheral data mover with per-peripheral register windows and a bus master port.
`timescale 1ns/1ns
`include "pdm_map.vh"

module pdm_channels #(
  parameter NCH = `PDM_NUM_CH,
  parameter NPER = `PDM_NUM_PERIPH
) (
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire             clkEn,
  // Register window of each unit.
  input  wire [NPER-1:0]  regSel,
  input  wire [7:0]       regAddr,
  input  wire             regWr,
  input  wire [31:0]      regWdata,
  output reg  [31:0]      regRdata,
  // Peripheral request paths.
  input  wire [NPER-1:0]  rxReq,
  input  wire [NPER*16-1:0] rxData,
  output wire [NPER-1:0]  rxAck,
  input  wire [NPER-1:0]  txReq,
  output reg  [NPER-1:0]  txAck,
  output reg  [15:0]      txData,
  input  wire [NPER-1:0]  itemBytes2,
  output reg  [NCH-1:0]   endOfTransfer,
  // Memory bus master side.
  output wire             memValid,
  input  wire             memReady,
  output wire             memWrite,
  output wire [31:0]      memAddr,
  output wire [15:0]      memWdata,
  output wire [1:0]       memSize,
  input  wire             memRvalid,
  input  wire [15:0]      memRdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Channel registers; channel 2p is receive, 2p+1 is transmit of unit p.
  reg  [31:0] ptr_q [0:NCH-1];
  reg  [15:0] cnt_q [0:NCH-1];
  reg  [NCH-1:0] active_q;
  reg  [2:0]  grant_q;
  reg         busy_q;
  reg         rdWait_q;
  wire [NCH-1:0] want;
  reg  [2:0]  pick;
  reg         pickOk;
  integer     k;

  // Two-entry buffer toward the memory bus.
  reg  [49:0] buf_q [0:1];
  reg  [2:0]  bufCh_q [0:1];
  reg         bufHead_q;
  reg  [1:0]  bufCount_q;
  wire        bufFull = (bufCount_q == 2'h2);
  wire        bufPush;
  wire        bufPop = memValid && memReady;
  // The free slot sits one past the head while the buffer holds a word.
  wire        bufTail = bufHead_q ^ bufCount_q[0];
  // Receive channels queue a write of their item; transmit channels queue a read.
  wire        pushIsWrite = !pick[0];
  wire        pushSize    = itemBytes2[pick[2:1]];
  wire [31:0] pushAddr    = ptr_q[pick];
  wire [15:0] pushData    = rxData[pick[2:1]*16 +: 16];
  wire [31:0] pushStep    = pushSize ? 32'h00000002 : 32'h00000001;
  wire [49:0] pushWord    = {pushIsWrite,
                             pushSize,
                             pushAddr,
                             pushData};

  // Bus request fields come straight from the head entry's flip-flops.
  assign memValid  = (bufCount_q != 2'h0);
  assign memWrite  = buf_q[bufHead_q][49];
  assign memSize   = {1'b0, buf_q[bufHead_q][48]};
  assign memAddr   = buf_q[bufHead_q][47:16];
  assign memWdata  = buf_q[bufHead_q][15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel request qualification; even channels receive, odd transmit.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gReq
      if (g % 2 == 0) begin : gRx
        assign want[g] = active_q[g] && rxReq[g/2];
      end else begin : gTx
        assign want[g] = active_q[g] && txReq[g/2];
      end
    end
  endgenerate

  // Fixed priority; the downward scan leaves the lowest requesting channel.
  always @* begin
    pick = 3'h0;
    pickOk = 1'b0;
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      if (want[k]) begin
        pick = k[2:0];
        pickOk = 1'b1;
      end
    end
  end

  // Only one item is in flight, so a stalled read is never overtaken.
  // Pushing stalls while the buffer is full, so no item is lost.
  assign bufPush = clkEn && !busy_q && pickOk && !bufFull;
  assign rxAck = {NPER{1'b0}} | ({NPER{bufPush && !pick[0]}} & (4'h1 << pick[2:1]));

  ////////////////////////////////////////////////////////////////////////////
  // Offsets inside each unit's window, shared by read and write decode.
  wire        hitRxPtr = (regAddr == `PDM_OFS_PTR);
  wire        hitRxCnt = (regAddr == `PDM_OFS_CNT);
  wire        hitTxPtr = (regAddr == `PDM_OFS_TPTR);
  wire        hitTxCnt = (regAddr == `PDM_OFS_TCNT);

  // Register read decode within the selected unit's space.
  always @* begin
    regRdata = 32'h00000000;
    for (k = 0; k < NPER; k = k + 1) begin
      if (regSel[k]) begin
        if (hitRxPtr) begin
          regRdata = ptr_q[2*k];
        end else if (hitTxPtr) begin
          regRdata = ptr_q[2*k+1];
        end else if (hitRxCnt) begin
          regRdata = {16'h0000, cnt_q[2*k]};
        end else if (hitTxCnt) begin
          regRdata = {16'h0000, cnt_q[2*k+1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel state, transfers and buffer.
  // Synchronous reset; clkEn low freezes every register.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      for (k = 0; k < NCH; k = k + 1) begin
        ptr_q[k] <= `PDM_PTR_RESET;
        cnt_q[k] <= `PDM_CNT_RESET;
      end
      active_q <= {NCH{1'b0}};
      endOfTransfer <= {NCH{1'b0}};
      busy_q <= 1'b0;
      rdWait_q <= 1'b0;
      grant_q <= 3'h0;
      bufHead_q <= 1'b0;
      bufCount_q <= 2'h0;
      txAck <= {NPER{1'b0}};
      txData <= 16'h0000;
      buf_q[0] <= 50'h0;
      buf_q[1] <= 50'h0;
      bufCh_q[0] <= 3'h0;
      bufCh_q[1] <= 3'h0;
    end else if (clkEn) begin
      endOfTransfer <= {NCH{1'b0}};
      txAck <= {NPER{1'b0}};
      // A channel is armed one cycle after its count turns nonzero.
      for (k = 0; k < NCH; k = k + 1) begin
        active_q[k] <= (cnt_q[k] != 16'h0000);
      end
      // A queued item steps the pointer and retires one unit of count.
      if (bufPush) begin
        buf_q[bufTail] <= pushWord;
        bufCh_q[bufTail] <= pick;
        ptr_q[pick] <= ptr_q[pick] + pushStep;
        cnt_q[pick] <= cnt_q[pick] - 16'h0001;
        active_q[pick] <= 1'b0;
        if (cnt_q[pick] == 16'h0001) begin
          endOfTransfer[pick] <= 1'b1;
        end
        busy_q <= 1'b1;
        grant_q <= pick;
      end
      // The head entry leaves when the bus accepts it.
      if (bufPop) begin
        bufHead_q <= !bufHead_q;
        rdWait_q <= !memWrite;
        if (memWrite) begin
          busy_q <= 1'b0;
        end
      end
      bufCount_q <= bufCount_q + {1'b0, bufPush} - {1'b0, bufPop};
      // Returned read data goes to the owning transmitter as a one-cycle strobe.
      if (rdWait_q && memRvalid) begin
        rdWait_q <= 1'b0;
        busy_q <= 1'b0;
        txData <= memRdata;
        txAck[grant_q[2:1]] <= 1'b1;
      end
      // Software writes come last, so a count write overrides the decrement.
      for (k = 0; k < NPER; k = k + 1) begin
        if (regSel[k] && regWr) begin
          if (hitRxPtr) begin
            ptr_q[2*k] <= regWdata;
          end else if (hitTxPtr) begin
            ptr_q[2*k+1] <= regWdata;
          end else if (hitRxCnt) begin
            cnt_q[2*k] <= regWdata[15:0];
          end else if (hitTxCnt) begin
            cnt_q[2*k+1] <= regWdata[15:0];
          end
        end
      end
    end
  end

endmodule // pdm_channels

// ==== testbench/pdm_monitor.sv ====
// Port checks for the data mover.
`timescale 1ns/1ns
module pdm_monitor (
  input wire        sys_clk, rst_n, regWr, memValid, memReady, memWrite,
  input wire [3:0]  regSel, rxReq, rxAck, txAck,
  input wire [7:0]  regAddr, endOfTransfer,
  input wire [31:0] regRdata, memAddr,
  input wire [1:0]  memSize);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  hold_req_a: assert property (memValid && !memReady |=> memValid && $stable(memAddr))
    else $error("hold");
  rx_write_a: assert property (rxAck[0] |-> ##[0:1] memValid && memWrite)
    else $error("rxw");
  ack_cause_a: assert property (rxAck[0] |-> rxReq[0]) else $error("ack");
  eot_pulse_a: assert property (endOfTransfer[0] |=> !endOfTransfer[0]) else $error("eot");
  eot_stop_a: assert property (endOfTransfer[0] && !regWr |=> !rxAck[0]) else $error("stop");
  tx_pulse_a: assert property (txAck[3] |=> !txAck[3]) else $error("txa");
  item_size_a: assert property (memValid |-> !memSize[1]) else $error("size");
  unmapped_zero_a: assert property (regSel == 4'h1 && regAddr == 8'h0 |-> regRdata == 32'h0)
    else $error("unmap");
  cover property (endOfTransfer[6]);
  cover property (txAck[3]);
  cover property (memValid && !memReady);
endmodule // pdm_monitor
bind pdm_channels pdm_monitor mon (.*);

// ==== testbench/pdm_mem_model.sv ====
// Memory side: random stalls, read data one cycle after acceptance.
`timescale 1ns/1ns
module pdm_mem_model (
  input wire sys_clk, memValid, memWrite,
  input wire [31:0] memAddr,
  input wire [15:0] memWdata,
  input wire [1:0] memSize,
  output logic memReady, memRvalid,
  output logic [15:0] memRdata, lastData,
  output logic [1:0] lastSize,
  output logic [31:0] lastAddr);
  initial {memReady, memRvalid, memRdata, lastAddr, lastData, lastSize} = '0;
  always @(posedge sys_clk) begin
    memRvalid <= memValid && memReady && !memWrite;
    memRdata <= (memValid && memReady) ? memAddr[15:0] ^ 16'h5a5a : ~memRdata;
    if (memValid && memReady && memWrite) lastAddr <= memAddr;
    if (memValid && memReady && memWrite) lastData <= memWdata;
    if (memValid && memReady && memWrite) lastSize <= memSize;
    memReady <= 1'($urandom);
  end
endmodule // pdm_mem_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the data mover.
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic sys_clk, rst_n, regWr, memReady, memRvalid, memValid, memWrite;
  logic [3:0] regSel, rxReq, txReq, itemBytes2, rxAck, txAck;
  logic [7:0] regAddr, endOfTransfer, eotSeen;
  logic [31:0] regWdata, regRdata, memAddr, lastAddr, ptr, v;
  logic [63:0] rxData;
  logic [15:0] txData, memWdata, memRdata, cnt, lastData, dat;
  logic [1:0] memSize, lastSize;
  int n_errors = 0, check_count = 0;
  pdm_channels DUT (.clkEn(1'h1), .*);
  pdm_mem_model mem (.*);
  initial begin sys_clk = 0; forever #50 sys_clk = ~sys_clk; end
  initial begin #3000000; n_errors++; finish_test; end
  always @(posedge sys_clk) eotSeen <= rst_n ? eotSeen | endOfTransfer : 8'h0;
  task finish_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input int p, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) begin regSel <= 4'h1 << p; regAddr <= a; regWr <= 1'h1; regWdata <= d; end
    @(posedge sys_clk) regWr <= 1'h0;
  endtask
  task rd(input int p, input logic [7:0] a);
    @(posedge sys_clk) begin regSel <= 4'h1 << p; regAddr <= a; end
    @(negedge sys_clk) v = regRdata;
  endtask
  function logic [31:0] nxt(input logic [31:0] a, input int n, input logic s);
    return a + n * (s ? 2 : 1);
  endfunction
  initial begin
    {rst_n, regWr, regSel, regAddr, regWdata, rxReq, txReq, itemBytes2, rxData} = '0;
    void'($urandom(32'ha1cd3862));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(0, 8'h00); `CHK(v, 32'h0)
    for (int p = 0; p < 4; p++) begin
      rd(p, 8'h30); `CHK(v, 32'h0)
      rd(p, 8'h3c); `CHK(v[15:0], 16'h0)
      ptr = $urandom;
      cnt = 16'($urandom_range(4, 1));
      itemBytes2[p] <= 1'($urandom);
      wr(p, 8'h30, ptr);
      wr(p, 8'h34, {16'h0, cnt});
      repeat (cnt) begin
        @(posedge sys_clk) begin dat = 16'($urandom); rxReq[p] <= 1'h1; rxData[p*16 +: 16] <= dat; end
        do @(negedge sys_clk); while (rxAck[p] !== 1'h1);
        @(posedge sys_clk) rxReq[p] <= 1'h0;
      end
      repeat (30) @(posedge sys_clk);
      `CHK(lastAddr, nxt(ptr, cnt - 1, itemBytes2[p]))
      `CHK(lastData, dat)
      `CHK(lastSize, {1'b0, itemBytes2[p]})
      rd(p, 8'h30); `CHK(v, nxt(ptr, cnt, itemBytes2[p]))
      rd(p, 8'h34); `CHK(v[15:0], 16'h0)
      wr(p, 8'h38, ptr);
      wr(p, 8'h3c, 32'h1);
      @(posedge sys_clk) txReq[p] <= 1'h1;
      do @(negedge sys_clk); while (txAck[p] !== 1'h1);
      `CHK(txData, ptr[15:0] ^ 16'h5a5a)
      @(posedge sys_clk) txReq[p] <= 1'h0;
      $display("test %0d done", p);
    end
    repeat (10) @(posedge sys_clk);
    `CHK(eotSeen, 8'hff)
    finish_test;
  end
endmodule // tb_top
